/* ext_mmd_model.sv */
/*
 * extended register target behind the indirect access window.
 * assumes: the write target is the pointer value of the cycle before ext_wr,
 * since in the write-increment modes the window has already moved its pointer when the pulse arrives.
 */
module ext_mmd_model (
    // clock and reset
    input  wire logic        clock,
    input  wire logic        rst_b,
    // window side
    input  wire logic [15:0] ext_addr,
    input  wire logic        ext_wr,
    input  wire logic        ext_rd,
    input  wire logic [15:0] ext_wdata,
    output logic      [15:0] ext_rdata
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [15:0]  mem [0:255];
    logic [255:0] used;
    logic [15:0]  prev_addr;
    int           n_reads;
    // unwritten cells answer a pattern, so a stale bus cannot pass for data
    assign ext_rdata = used[ext_addr[7:0]] ? mem[ext_addr[7:0]] : ext_addr ^ 16'h5a5a;
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            prev_addr <= 16'h0000;
            used      <= '0;
            n_reads   <= 0;
        end else begin
            prev_addr <= ext_addr;
            if (ext_rd) begin
                n_reads <= n_reads + 1;
            end
            if (ext_wr) begin
                mem[prev_addr[7:0]]  <= ext_wdata;
                used[prev_addr[7:0]] <= 1'b1;
            end
        end
    end
endmodule : ext_mmd_model

/* gig_cfg_regs.sv */
/*
 * gigabit configuration / status register slice with the indirect
 * extended-register access pair and a fixed capability register.
 * assumes: a management frame engine presents a register address with
 * one-cycle read and write strobes; status levels come from the PMA
 * and are asynchronous; extended register read data is returned
 * combinationally for ext_addr.
 */
module gig_cfg_regs
    import gig_regs_pkg::*;
(
    // clock and reset
    input  wire logic              clock,
    input  wire logic              rst_b,
    // register access
    input  wire logic [REG_AW-1:0] reg_addr,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    input  wire logic [REG_DW-1:0] reg_wdata,
    output logic      [REG_DW-1:0] reg_rdata,
    // straps, sampled after reset release
    input  wire logic              strap_adv_fd,
    input  wire logic              strap_adv_hd,
    // line status (asynchronous)
    input  wire logic              role_fault_in,
    input  wire logic              role_master_in,
    input  wire logic              local_rx_ok_in,
    input  wire logic              remote_rx_ok_in,
    input  wire logic              partner_fd_in,
    input  wire logic              partner_hd_in,
    input  wire logic              link_up_in,
    input  wire logic [7:0]        idle_err_in,
    // control to the datapath
    output logic      [2:0]        test_mode,
    output logic                   manual_role_enable,
    output logic                   manual_role_value,
    output logic                   multi_port,
    output logic                   adv_gig_full_duplex,
    output logic                   adv_gig_half_duplex,
    output logic                   reflectometry_start,
    output logic      [15:0]       phy_general_control,
    // extended register access
    output logic      [EXT_AW-1:0] ext_addr,
    output logic                   ext_wr,
    output logic                   ext_rd,
    output logic      [REG_DW-1:0] ext_wdata,
    output logic      [4:0]        mmd_device_select,
    input  wire logic [REG_DW-1:0] ext_rdata
);
    localparam int ST_W = 15;

    logic [ST_W-1:0] st_sync;
    logic            fault_s;
    logic            master_s;
    logic            local_ok_s;
    logic            remote_ok_s;
    logic            pfd_s;
    logic            phd_s;
    logic            link_s;
    logic [7:0]      idle_s;

    // single bundle keeps all status on one synchroniser instance;
    // multi-bit idle count may tear, acceptable for a debug counter
    status_sync #(.WIDTH(ST_W)) u_sync (
        .clock    (clock),
        .rst_b    (rst_b),
        .async_in ({role_fault_in, role_master_in, local_rx_ok_in,
                    remote_rx_ok_in, partner_fd_in, partner_hd_in,
                    link_up_in, idle_err_in}),
        .sync_out (st_sync)
    );
    assign {fault_s, master_s, local_ok_s, remote_ok_s, pfd_s, phd_s,
            link_s, idle_s} = st_sync;

    logic [15:0] gig_config;
    logic [15:0] next_gig_config;
    logic [15:0] mmd_ctrl;
    logic [15:0] next_mmd_ctrl;
    logic [15:0] phy_ctrl;
    logic [15:0] next_phy_ctrl;
    logic        role_fault_latched;
    logic        next_role_fault_latched;
    logic        straps_taken;
    logic        next_straps_taken;
    logic        link_prev;
    logic        next_link_prev;
    logic        next_refl_start;
    logic [15:0] status_word;
    logic [15:0] next_rdata;
    logic        hit_cfg;
    logic        hit_sts;
    logic        hit_ctl;
    logic        hit_dat;
    logic        cfg_take;

    // strap pins: two flops with no reset, so the levels have settled by
    // the time reset lets go; reset must span at least two clocks
    logic [1:0]  strap_meta;
    logic [1:0]  next_strap_meta;
    logic [1:0]  strap_s;
    logic [1:0]  next_strap_s;

    always_comb begin
        next_strap_meta = {strap_adv_fd, strap_adv_hd};
        next_strap_s    = strap_meta;
    end

    always_ff @(posedge clock) begin
        strap_meta <= next_strap_meta;
        strap_s    <= next_strap_s;
    end

    always_comb begin
        hit_cfg = (reg_addr == OFS_GIG_CONFIG);
        hit_sts = (reg_addr == OFS_GIG_STATUS);
        hit_ctl = (reg_addr == OFS_MMD_CTRL);
        hit_dat = (reg_addr == OFS_MMD_ADDAT);
        cfg_take = straps_taken && reg_wr && hit_cfg;
        status_word = {role_fault_latched, master_s, local_ok_s, remote_ok_s,
                       pfd_s, phd_s, 2'b00, idle_s};

        next_gig_config = gig_config;
        next_straps_taken = 1'b1;
        if (!straps_taken) begin
            // strap levels caught on the first clock after release
            next_gig_config[ADV_FD_BIT] = strap_s[1];
            next_gig_config[ADV_HD_BIT] = strap_s[0];
        end else if (cfg_take) begin
            next_gig_config = reg_wdata & CONFIG_WMASK;
        end

        next_mmd_ctrl = mmd_ctrl;
        if (reg_wr && hit_ctl) begin
            next_mmd_ctrl = reg_wdata & MMD_CTRL_WMASK;
        end

        next_phy_ctrl = phy_ctrl;
        if (reg_wr && reg_addr == OFS_PHY_CTRL) begin
            next_phy_ctrl = reg_wdata;
        end

        // set wins over the clear-on-read
        next_role_fault_latched = role_fault_latched;
        if (reg_rd && hit_sts) begin
            next_role_fault_latched = 1'b0;
        end
        if (fault_s) begin
            next_role_fault_latched = 1'b1;
        end

        next_link_prev  = link_s;
        next_refl_start = gig_config[REFL_AUTO_BIT] && link_prev && !link_s;

        next_rdata = reg_rdata;
        if (reg_rd) begin
            case (reg_addr)
                OFS_GIG_CONFIG: next_rdata = gig_config;
                OFS_GIG_STATUS: next_rdata = status_word;
                OFS_MMD_CTRL:   next_rdata = mmd_ctrl;
                OFS_MMD_ADDAT: begin
                    if (mmd_ctrl[15:FUNC_LSB] == FUNC_ADDRESS) begin
                        next_rdata = ext_addr;
                    end else begin
                        next_rdata = ext_rdata;
                    end
                end
                OFS_GIG_CAP:    next_rdata = CAP_VALUE;
                OFS_PHY_CTRL:   next_rdata = phy_ctrl;
                default:        next_rdata = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            gig_config          <= RST_GIG_CONFIG;
            mmd_ctrl            <= 16'h0000;
            phy_ctrl            <= RST_PHY_CTRL;
            role_fault_latched  <= 1'b0;
            straps_taken        <= 1'b0;
            link_prev           <= 1'b0;
            reflectometry_start <= 1'b0;
            reg_rdata           <= 16'h0000;
        end else begin
            gig_config          <= next_gig_config;
            mmd_ctrl            <= next_mmd_ctrl;
            phy_ctrl            <= next_phy_ctrl;
            role_fault_latched  <= next_role_fault_latched;
            straps_taken        <= next_straps_taken;
            link_prev           <= next_link_prev;
            reflectometry_start <= next_refl_start;
            reg_rdata           <= next_rdata;
        end
    end

    // field outputs come straight from the config flops
    assign test_mode           = gig_config[TEST_MODE_LSB+2:TEST_MODE_LSB];
    assign manual_role_enable  = gig_config[MAN_ROLE_EN];
    assign manual_role_value   = gig_config[MAN_ROLE_VAL];
    assign multi_port          = gig_config[PORT_TYPE_BIT];
    assign adv_gig_full_duplex = gig_config[ADV_FD_BIT];
    assign adv_gig_half_duplex = gig_config[ADV_HD_BIT];
    assign phy_general_control = phy_ctrl;
    assign mmd_device_select   = mmd_ctrl[DEV_MSB:0];

    mmd_window u_window (
        .clock     (clock),
        .rst_b     (rst_b),
        .func      (mmd_ctrl[15:FUNC_LSB]),
        .wr_strobe (reg_wr && hit_dat),
        .rd_strobe (reg_rd && hit_dat),
        .wr_data   (reg_wdata),
        .ext_addr  (ext_addr),
        .ext_wr    (ext_wr),
        .ext_rd    (ext_rd),
        .ext_wdata (ext_wdata)
    );

    // config writes reach both the register and the field outputs
    cfg_write_a: assert property (@(posedge clock) disable iff (!rst_b)
        cfg_take
        |=> gig_config == ($past(reg_wdata) & CONFIG_WMASK))
        else $error("config write not stored");
    test_mode_a: assert property (@(posedge clock) disable iff (!rst_b)
        cfg_take |=> test_mode == $past(reg_wdata[TEST_MODE_LSB+2:TEST_MODE_LSB]))
        else $error("test mode not taken");
    man_enable_a: assert property (@(posedge clock) disable iff (!rst_b)
        cfg_take |=> manual_role_enable == $past(reg_wdata[MAN_ROLE_EN]))
        else $error("manual role enable not taken");
    man_value_a: assert property (@(posedge clock) disable iff (!rst_b)
        cfg_take |=> manual_role_value == $past(reg_wdata[MAN_ROLE_VAL]))
        else $error("manual role value not taken");
    port_type_a: assert property (@(posedge clock) disable iff (!rst_b)
        cfg_take |=> multi_port == $past(reg_wdata[PORT_TYPE_BIT]))
        else $error("port type not taken");
    adv_write_a: assert property (@(posedge clock) disable iff (!rst_b)
        cfg_take |=> {adv_gig_full_duplex, adv_gig_half_duplex}
            == $past({reg_wdata[ADV_FD_BIT], reg_wdata[ADV_HD_BIT]}))
        else $error("advertisement not taken");
    strap_load_a: assert property (@(posedge clock) disable iff (!rst_b)
        !straps_taken |=> {adv_gig_full_duplex, adv_gig_half_duplex} == $past(strap_s))
        else $error("strap levels not loaded");

    // latched fault: set beats the clear of a status read
    fault_hold_a: assert property (@(posedge clock) disable iff (!rst_b)
        (role_fault_latched && !(reg_rd && hit_sts)) |=> role_fault_latched)
        else $error("fault flag dropped without read");
    fault_set_a: assert property (@(posedge clock) disable iff (!rst_b)
        fault_s |=> role_fault_latched)
        else $error("fault not latched");
    fault_clear_a: assert property (@(posedge clock) disable iff (!rst_b)
        (reg_rd && hit_sts && !fault_s) |=> !role_fault_latched)
        else $error("fault not cleared by read");

    refl_start_a: assert property (@(posedge clock) disable iff (!rst_b)
        reflectometry_start |-> $past(gig_config[REFL_AUTO_BIT]) && !link_prev)
        else $error("reflectometry start without link-down");
    refl_fire_a: assert property (@(posedge clock) disable iff (!rst_b)
        (gig_config[REFL_AUTO_BIT] && link_prev && !link_s) |=> reflectometry_start)
        else $error("link-down did not start reflectometry");

    // reads answer on the edge after the strobe
    cap_read_a: assert property (@(posedge clock) disable iff (!rst_b)
        (reg_rd && reg_addr == OFS_GIG_CAP) |=> reg_rdata == CAP_VALUE)
        else $error("capability read wrong");
    status_read_a: assert property (@(posedge clock) disable iff (!rst_b)
        (reg_rd && hit_sts) |=> reg_rdata[7:0] == $past(idle_s)
            && reg_rdata[14] == $past(master_s))
        else $error("status read mismatch");
    receiver_read_a: assert property (@(posedge clock) disable iff (!rst_b)
        (reg_rd && hit_sts) |=> reg_rdata[13:12] == $past({local_ok_s, remote_ok_s}))
        else $error("receiver bits mismatch");
    partner_read_a: assert property (@(posedge clock) disable iff (!rst_b)
        (reg_rd && hit_sts) |=> reg_rdata[11:10] == $past({pfd_s, phd_s}))
        else $error("partner bits mismatch");

    // indirect access control and the address/data window
    ctrl_mask_a: assert property (@(posedge clock) disable iff (!rst_b)
        (reg_wr && hit_ctl) |=> (mmd_ctrl & ~MMD_CTRL_WMASK) == 16'h0000)
        else $error("reserved control bits written");
    func_write_a: assert property (@(posedge clock) disable iff (!rst_b)
        (reg_wr && hit_ctl) |=> mmd_ctrl[15:FUNC_LSB] == $past(reg_wdata[15:FUNC_LSB]))
        else $error("function field not taken");
    addr_read_a: assert property (@(posedge clock) disable iff (!rst_b)
        (reg_rd && hit_dat && mmd_ctrl[15:FUNC_LSB] == FUNC_ADDRESS)
        |=> reg_rdata == $past(ext_addr))
        else $error("address function read wrong");
    data_read_a: assert property (@(posedge clock) disable iff (!rst_b)
        (reg_rd && hit_dat && mmd_ctrl[15:FUNC_LSB] != FUNC_ADDRESS)
        |=> reg_rdata == $past(ext_rdata))
        else $error("data function read wrong");
endmodule : gig_cfg_regs

/* gig_regs_pkg.sv */
/*
 * constants for the gigabit management register slice: register offsets,
 * field positions, reset values and mode encodings.
 * assumes: 5-bit management register address, 16-bit register data.
 */
package gig_regs_pkg;

    localparam int          REG_AW        = 5;
    localparam int          REG_DW        = 16;
    localparam int          EXT_AW        = 16;

    // register offsets
    localparam logic [4:0]  OFS_GIG_CONFIG = 5'h09;
    localparam logic [4:0]  OFS_GIG_STATUS = 5'h0a;
    localparam logic [4:0]  OFS_MMD_CTRL   = 5'h0d;
    localparam logic [4:0]  OFS_MMD_ADDAT  = 5'h0e;
    localparam logic [4:0]  OFS_GIG_CAP    = 5'h0f;
    localparam logic [4:0]  OFS_PHY_CTRL   = 5'h10;

    // reset values
    localparam logic [15:0] RST_GIG_CONFIG = 16'h0300;
    localparam logic [15:0] RST_PHY_CTRL   = 16'h5048;
    localparam logic [15:0] CAP_VALUE      = 16'hf000;

    // gigabit_config fields
    localparam int          TEST_MODE_LSB  = 13;
    localparam int          MAN_ROLE_EN    = 12;
    localparam int          MAN_ROLE_VAL   = 11;
    localparam int          PORT_TYPE_BIT  = 10;
    localparam int          ADV_FD_BIT     = 9;
    localparam int          ADV_HD_BIT     = 8;
    localparam int          REFL_AUTO_BIT  = 7;
    localparam logic [15:0] CONFIG_WMASK   = 16'hff80;

    // gigabit_status fields
    localparam int          FAULT_BIT      = 15;

    // mmd_access_control fields
    localparam int          FUNC_LSB       = 14;
    localparam logic [15:0] MMD_CTRL_WMASK = 16'hc01f;
    localparam logic [4:0]  EXT_DEVICE     = 5'h1f;
    localparam int          DEV_MSB        = 4;

    typedef enum logic [1:0] {
        FUNC_ADDRESS  = 2'h0,
        FUNC_DATA     = 2'h1,
        FUNC_DATA_INC = 2'h2,
        FUNC_DATA_WINC = 2'h3
    } mmd_func_t;

    typedef enum logic [2:0] {
        TM_NORMAL     = 3'h0,
        TM_WAVEFORM   = 3'h1,
        TM_JIT_MASTER = 3'h2,
        TM_JIT_SLAVE  = 3'h3,
        TM_DISTORTION = 3'h4,
        TM_MLT3_IDLE  = 3'h5,
        TM_REP_0001   = 3'h6,
        TM_PULSE_63   = 3'h7
    } test_mode_t;

endpackage : gig_regs_pkg

/* mmd_window.sv */
/*
 * indirect extended-register window: holds the address pointer for the
 * selected device and applies the post-increment modes.
 * assumes: access strobes are one-cycle pulses on the management clock.
 */
module mmd_window
    import gig_regs_pkg::*;
(
    // clock and reset
    input  wire logic              clock,
    input  wire logic              rst_b,
    // control
    input  wire logic [1:0]        func,
    input  wire logic              wr_strobe,
    input  wire logic              rd_strobe,
    input  wire logic [REG_DW-1:0] wr_data,
    // extended register side
    output logic [EXT_AW-1:0]      ext_addr,
    output logic                   ext_wr,
    output logic                   ext_rd,
    output logic [REG_DW-1:0]      ext_wdata
);
    logic [EXT_AW-1:0] next_ext_addr;
    logic              next_ext_wr;
    logic              next_ext_rd;
    logic [REG_DW-1:0] next_ext_wdata;
    logic              is_data;
    logic              bump;

    always_comb begin
        is_data        = (func != FUNC_ADDRESS);
        next_ext_addr  = ext_addr;
        next_ext_wdata = ext_wdata;
        next_ext_wr    = wr_strobe && is_data;
        next_ext_rd    = rd_strobe && is_data;
        bump = (wr_strobe && (func == FUNC_DATA_INC || func == FUNC_DATA_WINC))
            || (rd_strobe && func == FUNC_DATA_INC);
        if (wr_strobe && !is_data) begin
            next_ext_addr = wr_data;
        end else if (bump) begin
            next_ext_addr = ext_addr + 16'h0001;
        end
        if (wr_strobe) begin
            next_ext_wdata = wr_data;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            ext_addr  <= '0;
            ext_wr    <= 1'b0;
            ext_rd    <= 1'b0;
            ext_wdata <= '0;
        end else begin
            ext_addr  <= next_ext_addr;
            ext_wr    <= next_ext_wr;
            ext_rd    <= next_ext_rd;
            ext_wdata <= next_ext_wdata;
        end
    end

    // address latches only in address function
    addr_hold_a: assert property (@(posedge clock) disable iff (!rst_b)
        (wr_strobe && func == FUNC_DATA) |=> ext_addr == $past(ext_addr))
        else $error("address moved in no-increment mode");
    read_inc_a: assert property (@(posedge clock) disable iff (!rst_b)
        (rd_strobe && !wr_strobe && func == FUNC_DATA_INC)
        |=> ext_addr == $past(ext_addr) + 16'h0001)
        else $error("read did not increment address");
    wonly_read_a: assert property (@(posedge clock) disable iff (!rst_b)
        (rd_strobe && !wr_strobe && func == FUNC_DATA_WINC)
        |=> ext_addr == $past(ext_addr))
        else $error("read incremented in write-only mode");
endmodule : mmd_window

/* status_sync.sv */
/*
 * two-flop synchroniser for a bundle of status levels.
 * assumes: inputs come from outside the management clock domain.
 */
module status_sync
    import gig_regs_pkg::*;
#(
    parameter int WIDTH = 1
) (
    // clock and reset
    input  wire logic             clock,
    input  wire logic             rst_b,
    // levels
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] next_stage1;
    logic [WIDTH-1:0] next_sync_out;

    always_comb begin
        next_stage1   = async_in;
        next_sync_out = stage1;
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            stage1   <= '0;
            sync_out <= '0;
        end else begin
            stage1   <= next_stage1;
            sync_out <= next_sync_out;
        end
    end
endmodule : status_sync

/* tb_top.sv */
/*
 * self-checking bench for gig_cfg_regs with an extended register model.
 * assumes: one 200 MHz clock, one-cycle strobes, requests from the
 * second edge after reset release.
 */
module tb_top
    import gig_regs_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic              clock;
    logic              rst_b;
    logic [REG_AW-1:0] reg_addr;
    logic              reg_wr;
    logic              reg_rd;
    logic [REG_DW-1:0] reg_wdata;
    logic [REG_DW-1:0] reg_rdata;
    logic              strap_adv_fd;
    logic              strap_adv_hd;
    logic [5:0]        st;
    logic              link_up_in;
    logic [7:0]        idle_err_in;
    logic [7:0]        cfg_out;
    logic              reflectometry_start;
    logic [15:0]       phy_general_control;
    logic [15:0]       ext_addr;
    logic              ext_wr;
    logic              ext_rd;
    logic [15:0]       ext_wdata;
    logic [4:0]        mmd_device_select;
    logic [15:0]       ext_rdata;
    logic [31:0]       seed;
    int                n_mismatch;
    int                num_checks;
    int                cycles;
    int                n_refl;

    gig_cfg_regs DUT (
        .clock(clock), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .strap_adv_fd(strap_adv_fd), .strap_adv_hd(strap_adv_hd),
        .role_fault_in(st[5]), .role_master_in(st[4]), .local_rx_ok_in(st[3]),
        .remote_rx_ok_in(st[2]), .partner_fd_in(st[1]), .partner_hd_in(st[0]),
        .link_up_in(link_up_in), .idle_err_in(idle_err_in),
        .test_mode(cfg_out[7:5]), .manual_role_enable(cfg_out[4]),
        .manual_role_value(cfg_out[3]), .multi_port(cfg_out[2]),
        .adv_gig_full_duplex(cfg_out[1]), .adv_gig_half_duplex(cfg_out[0]),
        .reflectometry_start(reflectometry_start),
        .phy_general_control(phy_general_control), .ext_addr(ext_addr),
        .ext_wr(ext_wr), .ext_rd(ext_rd), .ext_wdata(ext_wdata),
        .mmd_device_select(mmd_device_select), .ext_rdata(ext_rdata));

    ext_mmd_model mmd (
        .clock(clock), .rst_b(rst_b), .ext_addr(ext_addr), .ext_wr(ext_wr),
        .ext_rd(ext_rd), .ext_wdata(ext_wdata), .ext_rdata(ext_rdata));

    function automatic logic [15:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[15:0];
    endfunction : xs

    function automatic logic [15:0] exp_rd(int f, logic [15:0] a, int k, logic [15:0] d);
        case (f)
            1: return ~d;
            2: return (a + 16'(2 + k)) ^ 16'h5a5a;
            default: return (a + 16'h0002) ^ 16'h5a5a;
        endcase
    endfunction : exp_rd

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : print_verdict

    task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp16

    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge clock);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask : wr

    // one spare edge so the answer is settled whatever its exact latency
    task automatic chk(input logic [4:0] a, input logic [15:0] e);
        @(posedge clock);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        @(posedge clock);
        #1 cmp16(reg_rdata, e);
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask : tick

    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    always @(posedge clock) begin
        cycles++;
        if (reflectometry_start === 1'b1) n_refl++;
        // whole run needs some 280 cycles
        if (cycles == 20000) begin
            n_mismatch++;
            print_verdict();
        end
    end

    initial begin
        logic [15:0] d;
        logic [15:0] a;
        logic [5:0]  s;
        logic [7:0]  i;
        seed = 32'd6882;
        rst_b = 1'b0;
        reg_addr = '0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = '0;
        strap_adv_fd = 1'b1;
        strap_adv_hd = 1'b0;
        st = '0;
        link_up_in = 1'b1;
        idle_err_in = '0;
        tick(4);
        rst_b <= 1'b1;
        tick(1);
        chk(OFS_GIG_CONFIG, 16'h0200);
        cmp16({8'h00, cfg_out}, 16'h0002);
        chk(OFS_GIG_STATUS, 16'h0000);
        chk(OFS_MMD_CTRL, 16'h0000);
        chk(OFS_MMD_ADDAT, 16'h0000);
        chk(OFS_GIG_CAP, CAP_VALUE);
        chk(OFS_PHY_CTRL, RST_PHY_CTRL);
        chk(5'h1f, 16'h0000);
        $display("test done: reset values");
        for (int m = 0; m < 8; m++) begin
            d = xs();
            d[15:13] = 3'(m);
            wr(OFS_GIG_CONFIG, d);
            chk(OFS_GIG_CONFIG, d & 16'hff80);
            cmp16({8'h00, cfg_out}, {8'h00, d[15:8]});
        end
        wr(OFS_GIG_CAP, 16'hffff);
        chk(OFS_GIG_CAP, 16'hf000);
        wr(OFS_GIG_STATUS, 16'hffff);
        chk(OFS_GIG_STATUS, 16'h0000);
        d = xs();
        wr(OFS_PHY_CTRL, d);
        chk(OFS_PHY_CTRL, d);
        cmp16(phy_general_control, d);
        $display("test done: config and read-only");
        for (int n = 0; n < 4; n++) begin
            s = {1'b0, 5'(xs())};
            i = 8'(xs());
            @(posedge clock);
            st <= s;
            idle_err_in <= i;
            tick(5);
            chk(OFS_GIG_STATUS, {s, 2'b00, i});
        end
        @(posedge clock);
        st[5] <= 1'b1;
        tick(4);
        st[5] <= 1'b0;
        tick(5);
        chk(OFS_GIG_STATUS, {1'b1, s[4:0], 2'b00, i});
        chk(OFS_GIG_STATUS, {1'b0, s[4:0], 2'b00, i});
        $display("test done: status");
        for (int en = 1; en >= 0; en--) begin
            wr(OFS_GIG_CONFIG, en ? 16'h0080 : 16'h0000);
            n_refl = 0;
            @(posedge clock);
            link_up_in <= 1'b0;
            tick(8);
            cmp16(16'(n_refl), 16'(en));
            link_up_in <= 1'b1;
            tick(6);
        end
        $display("test done: reflectometry");
        for (int f = 1; f < 4; f++) begin
            a = xs();
            a[7:0] = {3'(f), 5'h00};
            d = xs();
            wr(OFS_MMD_CTRL, {7'h00, 4'h0, EXT_DEVICE});
            wr(OFS_MMD_ADDAT, a);
            chk(OFS_MMD_ADDAT, a);
            // reserved bits set on purpose, they must read back clear
            wr(OFS_MMD_CTRL, {2'(f), 9'h1ff, EXT_DEVICE});
            chk(OFS_MMD_CTRL, {2'(f), 9'h000, EXT_DEVICE});
            cmp16({11'h000, mmd_device_select}, 16'h001f);
            wr(OFS_MMD_ADDAT, d);
            wr(OFS_MMD_ADDAT, ~d);
            for (int k = 0; k < 2; k++) begin
                chk(OFS_MMD_ADDAT, exp_rd(f, a, k, d));
            end
            cmp16(ext_addr, a + 16'((f == 2) ? 4 : (f == 3) ? 2 : 0));
            wr(OFS_MMD_CTRL, {7'h00, 4'h0, EXT_DEVICE});
            wr(OFS_MMD_ADDAT, a);
            wr(OFS_MMD_CTRL, {2'b01, 9'h000, EXT_DEVICE});
            chk(OFS_MMD_ADDAT, (f == 1) ? ~d : d);
        end
        cmp16(16'(mmd.n_reads), 16'h0009);
        $display("test done: extended access");
        // second reset in mid-run, straps flipped
        @(posedge clock);
        strap_adv_fd <= 1'b0;
        strap_adv_hd <= 1'b1;
        rst_b        <= 1'b0;
        tick(4);
        rst_b <= 1'b1;
        tick(1);
        chk(OFS_GIG_CONFIG, 16'h0100);
        cmp16({8'h00, cfg_out}, 16'h0001);
        chk(OFS_MMD_CTRL, 16'h0000);
        chk(OFS_GIG_STATUS, {1'b0, s[4:0], 2'b00, i});
        $display("test done: reset in run");
        print_verdict();
    end
endmodule : tb_top
